// ==== logic/dual_wdt_regs.vh ====
`ifndef DUAL_WDT_REGS_VH
`define DUAL_WDT_REGS_VH

// Register byte offsets
`define KEY_OFS        8'h00
`define PSC_OFS        8'h04
`define RLD_OFS        8'h08
`define ISTS_OFS       8'h0c
`define WCTRL_OFS      8'h10
`define WCFG_OFS       8'h14
`define WSTS_OFS       8'h18

// Key command codes
`define KEY_UNLOCK     16'h5555
`define KEY_RELOAD     16'haaaa
`define KEY_START      16'hcccc

// Reset values
`define PSC_RST        3'h0
`define RLD_RST        12'hfff
`define WCNT_RST       7'h7f
`define WWIN_RST       7'h7f
`define WTB_RST        2'h0

// Field positions
`define WEN_BIT        7
`define WTB_LSB        7
`define WTB_MSB        8
`define EWIE_BIT       9
`define PSC_PEND_BIT   0
`define RLD_PEND_BIT   1
`define EWF_BIT        0

// Window counter thresholds and timebase
`define WCNT_WARN      7'h40
`define WCNT_PRE_WARN  7'h41
`define WTB_BASE_MASK  15'h0fff
`define WPRE_ZERO      15'h0000

// Independent divider base (divide by 4) and counter end
`define IDIV_BASE      9'h004
`define IDIV_MAX_SHIFT 3'h6
`define ICNT_END       12'h000

`endif

// ==== logic/indep_wdt_core.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dual_wdt_regs.vh"

module indep_wdt_core (
    input  wire        sys_clk_i,     // System clock
    input  wire        srst_i,        // Synchronous reset, high
    input  wire        lsi_tick_i,    // One pulse per independent clock rising edge
    input  wire        hw_mode_i,     // Hardware watchdog option
    input  wire        start_i,       // Start command pulse
    input  wire        reload_i,      // Reload command pulse
    input  wire        psc_wr_i,      // Accepted divider write
    input  wire [2:0]  psc_wdata_i,   // Divider code written
    input  wire        rld_wr_i,      // Accepted reload value write
    input  wire [11:0] rld_wdata_i,   // Reload value written
    output wire [2:0]  psc_o,         // Stored divider code
    output wire [11:0] rld_o,         // Stored reload value
    output wire        psc_pend_o,    // Divider update pending
    output wire        rld_pend_o,    // Reload update pending
    output wire        timeout_o      // Counter expired, sticky
);
    reg [2:0]  psc_r;
    reg [2:0]  psc_act_r;
    reg [11:0] rld_r;
    reg        psc_pend_r;
    reg        rld_pend_r;
    reg        run_r;
    reg [7:0]  div_cnt_r;
    reg [11:0] cnt_r;
    reg        timeout_r;

    // Code 7 uses the same span as code 6
    wire [2:0] shift_sel = (psc_act_r > `IDIV_MAX_SHIFT) ? `IDIV_MAX_SHIFT : psc_act_r;
    wire [8:0] div_span  = `IDIV_BASE << shift_sel;
    wire [8:0] div_m1    = div_span - 9'h001;
    wire       div_done  = lsi_tick_i && (div_cnt_r == div_m1[7:0]);

    // Stored values and their pending flags; a new divider code is taken up at the next tick
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            psc_r      <= `PSC_RST;
            psc_act_r  <= `PSC_RST;
            rld_r      <= `RLD_RST;
            psc_pend_r <= 1'b0;
            rld_pend_r <= 1'b0;
        end else begin
            if (psc_wr_i && !psc_pend_r) begin
                psc_r      <= psc_wdata_i;
                psc_pend_r <= 1'b1;
            end else if (lsi_tick_i && psc_pend_r) begin
                psc_act_r  <= psc_r;
                psc_pend_r <= 1'b0;
            end
            if (rld_wr_i && !rld_pend_r) begin
                rld_r      <= rld_wdata_i;
                rld_pend_r <= 1'b1;
            end else if (lsi_tick_i && rld_pend_r) begin
                rld_pend_r <= 1'b0;
            end
        end
    end

    // Prescaler and down counter
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            run_r     <= 1'b0;
            div_cnt_r <= 8'h00;
            cnt_r     <= `RLD_RST;
            timeout_r <= 1'b0;
        end else begin
            run_r <= run_r | start_i | hw_mode_i;
            if (reload_i) begin
                cnt_r <= rld_r;
            end else if (run_r && div_done && cnt_r != `ICNT_END) begin
                cnt_r <= cnt_r - 12'h001;
            end
            if (!run_r || div_done) begin
                div_cnt_r <= 8'h00;
            end else if (lsi_tick_i) begin
                div_cnt_r <= div_cnt_r + 8'h01;
            end
            if (run_r && cnt_r == `ICNT_END) begin
                timeout_r <= 1'b1;
            end
        end
    end

    assign psc_o      = psc_r;
    assign rld_o      = rld_r;
    assign psc_pend_o = psc_pend_r;
    assign rld_pend_o = rld_pend_r;
    assign timeout_o  = timeout_r;
endmodule

`default_nettype wire

// ==== logic/dual_watchdog_timer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dual_wdt_regs.vh"

module dual_watchdog_timer (
    input  wire        sys_clk_i,        // System clock, 125 MHz
    input  wire        srst_i,           // Synchronous reset, high
    input  wire        psel_i,           // APB select
    input  wire        penable_i,        // APB enable
    input  wire        pwrite_i,         // APB direction, 1 = write
    input  wire [7:0]  paddr_i,          // APB byte address
    input  wire [31:0] pwdata_i,         // APB write data
    input  wire [3:0]  pstrb_i,          // APB byte strobes
    output wire [31:0] prdata_o,         // APB read data
    output wire        pready_o,         // APB ready
    output wire        pslverr_o,        // APB error, unmapped address
    input  wire        lsi_clk_i,        // Independent watchdog clock pin
    input  wire        hw_wdt_opt_i,     // Hardware watchdog option pin
    output wire        early_warn_irq_o, // Early warning interrupt
    output wire        sys_rst_req_o     // System reset request, sticky
);
    // Register map, one aligned word each
    //   0x00  key, write only, reads zero
    //   0x04  divider code in bits 2:0
    //   0x08  reload value in bits 11:0
    //   0x0c  pending flags, bit 0 divider, bit 1 reload
    //   0x10  window control, count in 6:0, enable in 7
    //   0x14  window config, window 6:0, timebase 8:7
    //         and early warning enable in bit 9
    //   0x18  window status, early warning flag in bit 0
    //   Above 0x18 or misaligned: error answer
    //   Writes there are dropped, reads give zero

    // Reset values
    //   Window count and window both 0x7f
    //   Timebase, enables and flags all zero
    //   Divider code zero, reload value 0xfff
    //   Independent counter 0xfff and stopped

    // Bus timing
    //   A setup cycle is seen at one edge
    //   Ready comes in the very next cycle
    //   Ready, error and read data stand one cycle
    //   Writes act at the edge closing the access
    //   Back to back transfers are accepted

    // Byte strobes
    //   Half-word and word writes both work
    //   Lanes without a strobe keep their old bits
    //   A key write needs both low lanes
    //   Window control and status need lane 0

    // Independent side
    //   Key commands are decoded at the access edge
    //   Start and reload pulses reach the core a cycle later
    //   The unlock key opens divider and reload writes
    //   Any other key, reload included, locks again
    //   Locked writes are dropped without a trace
    //   A write while its flag is pending is dropped too
    //   Pending flags clear at the next slow clock tick
    //   A new divider code takes effect at that tick
    //   The slow clock pin passes two flip-flops first
    //   A third flop finds its rising edges
    //   The hardware option pin is synchronised alike
    //   With that option the counter runs with no start key

    // Window side
    //   The prescaler runs freely from the bus clock
    //   The counter steps every 4096 bus clocks
    //   Each timebase step doubles that span
    //   The counter keeps stepping while disabled
    //   A control write reloads the count
    //   Enable is sticky; only the system reset clears it
    //   Reset causes need the enable set before the write
    //   Stepping from 0x40 to 0x3f asks for a reset
    //   So does a reload while the count is above the window value
    //   And a reload with bit 6 clear
    //   A control write beats a step in the same cycle

    // Early warning
    //   The flag sets on the step from 0x41 to 0x40
    //   A zero written to the status bit drops it
    //   A new event beats a clear in the same cycle
    //   The interrupt is the flag gated by its enable
    //   It changes at the same edge as the flag, a cycle late if an event meets a clear

    // Reset request
    //   Either watchdog may raise it
    //   It stays high until the system reset arrives
    //   The independent counter stops at zero
    //   The window counter wraps after 0x00
    //   Software must reload between the window value
    //   and 0x40 to stay clear of a reset

    // Bus registers
    reg [31:0] rd_mux;
    reg        pready_r;
    reg        pslverr_r;
    reg [31:0] prdata_r;

    // Pin synchronisers
    reg        lsi_s1_r;
    reg        lsi_s2_r;
    reg        lsi_s3_r;
    reg        hw_s1_r;
    reg        hw_s2_r;

    // Independent watchdog access control
    reg        unlock_r;
    reg        start_r;
    reg        reload_r;
    reg        psc_wr_r;
    reg        rld_wr_r;
    reg [2:0]  psc_wdata_r;
    reg [11:0] rld_wdata_r;

    // Window watchdog state
    reg [14:0] wpre_r;
    reg [6:0]  wcnt_r;
    reg        wen_r;
    reg [6:0]  win_r;
    reg [1:0]  wtb_r;
    reg        ewie_r;
    reg        ewf_r;
    reg        irq_r;
    reg        rst_req_r;

    wire [31:0] wmask;
    wire [2:0]  psc_cur;
    wire [11:0] rld_cur;
    wire        psc_pend;
    wire        rld_pend;
    wire        independent_watchdog_timeout;

    // Byte strobes widened to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign wmask[gi*8+7:gi*8] = {8{pstrb_i[gi]}};
        end
    endgenerate

    // Bus phases: setup, then one access cycle with pready high
    wire setup    = psel_i && !penable_i;
    wire access   = psel_i && penable_i && pready_r;
    wire wr_acc   = access && pwrite_i;
    wire aligned  = (paddr_i[1:0] == 2'b00);
    wire mapped   = aligned && (paddr_i <= `WSTS_OFS);

    wire sel_key  = wr_acc && (paddr_i == `KEY_OFS);
    wire sel_psc  = wr_acc && (paddr_i == `PSC_OFS);
    wire sel_rld  = wr_acc && (paddr_i == `RLD_OFS);
    wire sel_wctl = wr_acc && (paddr_i == `WCTRL_OFS);
    wire sel_wcfg = wr_acc && (paddr_i == `WCFG_OFS);
    wire sel_wsts = wr_acc && (paddr_i == `WSTS_OFS);

    // Key needs both low lanes; half-word and word writes both qualify
    wire key_full = (pstrb_i[1:0] == 2'b11);
    wire key_wr   = sel_key && key_full;
    wire [15:0] key_val = pwdata_i[15:0];

    // Merged write data for partially strobed writes
    wire [31:0] rld_old  = {20'h00000, rld_cur};
    wire [31:0] rld_mrg  = (rld_old & ~wmask) | (pwdata_i & wmask);
    wire [31:0] wcfg_old = {22'h000000, ewie_r, wtb_r, win_r};
    wire [31:0] wcfg_mrg = (wcfg_old & ~wmask) | (pwdata_i & wmask);

    // Window timebase: low 12+tb bits of the prescaler all ones
    wire [14:0] wpre_mask = ((`WTB_BASE_MASK + 15'h0001) << wtb_r) - 15'h0001;
    wire        wtick     = ((wpre_r & wpre_mask) == wpre_mask);

    // Window reset causes
    wire wctl_wr   = sel_wctl && pstrb_i[0];
    wire w_early   = wen_r && wctl_wr && (wcnt_r > win_r);
    wire w_under   = wen_r && wtick && !wctl_wr && (wcnt_r == `WCNT_WARN);
    wire w_low_wr  = wen_r && wctl_wr && !pwdata_i[6];
    wire w_reset   = w_early || w_under || w_low_wr;

    // Early warning event: counter steps onto 0x40
    wire ew_event  = wtick && !wctl_wr && (wcnt_r == `WCNT_PRE_WARN);
    wire ew_clear  = sel_wsts && pstrb_i[0] && !pwdata_i[`EWF_BIT];

    // Two-flop synchronisers; the third stage only feeds the edge detect
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            lsi_s1_r <= 1'b0;
            lsi_s2_r <= 1'b0;
            lsi_s3_r <= 1'b0;
            hw_s1_r  <= 1'b0;
            hw_s2_r  <= 1'b0;
        end else begin
            lsi_s1_r <= lsi_clk_i;
            lsi_s2_r <= lsi_s1_r;
            lsi_s3_r <= lsi_s2_r;
            hw_s1_r  <= hw_wdt_opt_i;
            hw_s2_r  <= hw_s1_r;
        end
    end

    wire lsi_tick = lsi_s2_r && !lsi_s3_r;

    // Read data selected by address; the key always reads zero
    always @* begin
        rd_mux = 32'h00000000;
        case (paddr_i)
            `KEY_OFS:   rd_mux = 32'h00000000;
            `PSC_OFS:   rd_mux = {29'h00000000, psc_cur};
            `RLD_OFS:   rd_mux = {20'h00000, rld_cur};
            `ISTS_OFS:  rd_mux = {30'h00000000, rld_pend, psc_pend};
            `WCTRL_OFS: rd_mux = {24'h000000, wen_r, wcnt_r};
            `WCFG_OFS:  rd_mux = {22'h000000, ewie_r, wtb_r, win_r};
            `WSTS_OFS:  rd_mux = {31'h00000000, ewf_r};
            default:    rd_mux = 32'h00000000;
        endcase
    end

    // APB answer: ready, error and read data prepared during setup
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            prdata_r  <= 32'h00000000;
            if (setup && !pwrite_i && mapped) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // Key commands and write protection
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            unlock_r <= 1'b0;
            start_r  <= 1'b0;
            reload_r <= 1'b0;
        end else begin
            start_r  <= key_wr && (key_val == `KEY_START);
            reload_r <= key_wr && (key_val == `KEY_RELOAD);
            if (key_wr) begin
                unlock_r <= (key_val == `KEY_UNLOCK);
            end
        end
    end

    // Protected writes forwarded to the counter core
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            psc_wr_r    <= 1'b0;
            rld_wr_r    <= 1'b0;
            psc_wdata_r <= `PSC_RST;
            rld_wdata_r <= `RLD_RST;
        end else begin
            psc_wr_r    <= sel_psc && pstrb_i[0] && unlock_r;
            rld_wr_r    <= sel_rld && (pstrb_i[1:0] != 2'b00) && unlock_r;
            psc_wdata_r <= pwdata_i[2:0];
            rld_wdata_r <= rld_mrg[11:0];
        end
    end

    indep_wdt_core u_core (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .lsi_tick_i  (lsi_tick),
        .hw_mode_i   (hw_s2_r),
        .start_i     (start_r),
        .reload_i    (reload_r),
        .psc_wr_i    (psc_wr_r),
        .psc_wdata_i (psc_wdata_r),
        .rld_wr_i    (rld_wr_r),
        .rld_wdata_i (rld_wdata_r),
        .psc_o       (psc_cur),
        .rld_o       (rld_cur),
        .psc_pend_o  (psc_pend),
        .rld_pend_o  (rld_pend),
        .timeout_o   (independent_watchdog_timeout)
    );

    // Window prescaler runs freely from the bus clock
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            wpre_r <= `WPRE_ZERO;
        end else begin
            wpre_r <= wpre_r + 15'h0001;
        end
    end

    // Window counter: free running down count, reload by control write
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            wcnt_r <= `WCNT_RST;
            wen_r  <= 1'b0;
        end else begin
            if (wctl_wr) begin
                wcnt_r <= pwdata_i[6:0];
                wen_r  <= wen_r | pwdata_i[`WEN_BIT];
            end else if (wtick) begin
                wcnt_r <= wcnt_r - 7'h01;
            end
        end
    end

    // Window configuration; early warning enable is set only
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            win_r  <= `WWIN_RST;
            wtb_r  <= `WTB_RST;
            ewie_r <= 1'b0;
        end else if (sel_wcfg) begin
            win_r  <= wcfg_mrg[6:0];
            wtb_r  <= wcfg_mrg[`WTB_MSB:`WTB_LSB];
            ewie_r <= ewie_r | wcfg_mrg[`EWIE_BIT];
        end
    end

    // Early warning flag: a new event beats a clear in the same cycle
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            ewf_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            if (ew_event) begin
                ewf_r <= 1'b1;
            end else if (ew_clear) begin
                ewf_r <= 1'b0;
            end
            irq_r <= (ewf_r || ew_event) && ewie_r && !ew_clear;
        end
    end

    // System reset request holds until the system reset arrives
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            rst_req_r <= 1'b0;
        end else if (w_reset || independent_watchdog_timeout) begin
            rst_req_r <= 1'b1;
        end
    end

    assign prdata_o         = prdata_r;
    assign pready_o         = pready_r;
    assign pslverr_o        = pslverr_r;
    assign early_warn_irq_o = irq_r;
    assign sys_rst_req_o    = rst_req_r;
endmodule

`default_nettype wire

// ==== dv/dual_wdt_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dual_wdt_regs.vh"

module dual_wdt_asserts (
    input wire logic        sys_clk_i,        // Clock
    input wire logic        srst_i,           // Reset
    input wire logic        psel_i,           // Select
    input wire logic        penable_i,        // Enable
    input wire logic        pwrite_i,         // Direction
    input wire logic [7:0]  paddr_i,          // Address
    input wire logic [31:0] pwdata_i,         // Write data
    input wire logic [3:0]  pstrb_i,          // Strobes
    input wire logic [31:0] prdata_o,         // Read data
    input wire logic        pready_o,         // Ready
    input wire logic        pslverr_o,        // Error
    input wire logic        early_warn_irq_o, // Early warning
    input wire logic        sys_rst_req_o     // Reset request
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    // Access cycle decode
    wire rd_acc = pready_o && psel_i && penable_i && !pwrite_i;
    wire bad    = (paddr_i > 8'h18) || (paddr_i[1:0] != 2'h0);
    wire clr_wr = psel_i && penable_i && pwrite_i && paddr_i == `WSTS_OFS && pstrb_i[0];

    a_ready_follows: assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready missing after setup");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (psel_i && !penable_i && bad |=> pslverr_o)
        else $error("no error on unmapped access");
    a_mapped_ok: assert property (pready_o && !bad |-> !pslverr_o)
        else $error("error on mapped access");
    a_key_zero: assert property (rd_acc && paddr_i == `KEY_OFS |-> prdata_o == 32'h0)
        else $error("key register read not zero");
    a_div_width: assert property (rd_acc && paddr_i == `PSC_OFS |-> prdata_o[31:3] == 29'h0)
        else $error("divider read wider than code");
    a_rst_sticky: assert property (sys_rst_req_o |=> sys_rst_req_o)
        else $error("reset request dropped");
    a_quiet_release: assert property ($fell(srst_i) |-> !sys_rst_req_o && !early_warn_irq_o)
        else $error("output active right after reset");
    a_irq_clears: assert property (clr_wr && !pwdata_i[0] |=> ##1 !early_warn_irq_o)
        else $error("early warning not cleared");
endmodule

bind dual_watchdog_timer dual_wdt_asserts u_chk (.sys_clk_i, .srst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .early_warn_irq_o, .sys_rst_req_o);
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dual_wdt_regs.vh"

module tb_top;
    logic        sys_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0]  pstrb_i = 4'h0;
    logic        lsi_clk_i = 1'b0;
    logic        hw_wdt_opt_i = 1'b0;
    wire  [31:0] prdata_o;
    wire         pready_o;
    wire         pslverr_o;
    wire         early_warn_irq_o;
    wire         sys_rst_req_o;
    int          error_cnt = 0;
    int          compares = 0;

    dual_watchdog_timer dut (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .lsi_clk_i, .hw_wdt_opt_i,
        .early_warn_irq_o, .sys_rst_req_o);

    // 125 MHz clock
    always #4 sys_clk_i = ~sys_clk_i;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer, then one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        chk("pready", 32'h1, {31'h0, pready_o});
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, s, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, r, e);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        rd(a, r);
        chk(nm, exp, r);
    endtask

    // Reset request sampled before this edge's updates land
    task automatic chk_rst(input logic exp);
        @(posedge sys_clk_i);
        chk("reset request", {31'h0, exp}, {31'h0, sys_rst_req_o});
    endtask

    task automatic lsi(input int n);
        repeat (n) begin
            lsi_clk_i <= 1'b1;
            repeat (3) @(posedge sys_clk_i);
            lsi_clk_i <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
        end
    endtask

    task automatic do_reset(input logic hw);
        srst_i <= 1'b1;
        hw_wdt_opt_i <= hw;
        repeat (16) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic t_map();
        logic [31:0] r;
        logic        e;
        rdc("divider", `PSC_OFS, 32'h0);
        rdc("reload", `RLD_OFS, 32'hfff);
        rdc("pending", `ISTS_OFS, 32'h0);
        rdc("window ctrl", `WCTRL_OFS, 32'h7f);
        rdc("window cfg", `WCFG_OFS, 32'h7f);
        wr(`KEY_OFS, 32'h5555);
        rdc("key", `KEY_OFS, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, 4'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'b1, 8'h06, 32'h0, 4'hf, r, e);
        chk("misaligned err", 32'h1, {31'h0, e});
        $display("test map done");
    endtask

    task automatic t_protect();
        wr(`KEY_OFS, 32'h0);
        wr(`PSC_OFS, 32'h5);
        rdc("locked divider", `PSC_OFS, 32'h0);
        wr(`KEY_OFS, 32'h5555);
        wr(`PSC_OFS, 32'h3, 4'h3);
        rdc("divider pending", `ISTS_OFS, 32'h1);
        wr(`PSC_OFS, 32'h6);
        lsi(2);
        rdc("divider", `PSC_OFS, 32'h3);
        wr(`KEY_OFS, 32'h1234);
        wr(`RLD_OFS, 32'h123);
        rdc("relocked reload", `RLD_OFS, 32'hfff);
        wr(`KEY_OFS, 32'h5555);
        wr(`RLD_OFS, 32'h010, 4'h3);
        rdc("reload pending", `ISTS_OFS, 32'h2);
        lsi(2);
        rdc("reload", `RLD_OFS, 32'h010);
        $display("test protect done");
    endtask

    task automatic t_indep();
        do_reset(1'b0);
        wr(`KEY_OFS, 32'h5555);
        wr(`RLD_OFS, 32'h010);
        lsi(2);
        wr(`KEY_OFS, 32'haaaa);
        wr(`KEY_OFS, 32'hcccc);
        lsi(48);
        chk_rst(1'b0);
        wr(`KEY_OFS, 32'haaaa);
        lsi(48);
        chk_rst(1'b0);
        lsi(24);
        chk_rst(1'b1);
        do_reset(1'b1);
        wr(`KEY_OFS, 32'h5555);
        wr(`RLD_OFS, 32'h008);
        lsi(2);
        wr(`KEY_OFS, 32'haaaa);
        lsi(44);
        chk_rst(1'b1);
        do_reset(1'b0);
        $display("test independent done");
    endtask

    task automatic t_period(input logic [1:0] tb);
        logic [31:0] c;
        logic [31:0] r;
        int          n;
        int          p;
        p = 4096 << tb;
        n = 0;
        wr(`WCFG_OFS, {23'h0, tb, 7'h7f});
        rd(`WCTRL_OFS, c);
        r = c;
        while (r === c && n < p / 2) begin
            rd(`WCTRL_OFS, r);
            n++;
        end
        repeat (p - 24) @(posedge sys_clk_i);
        rdc("no tick yet", `WCTRL_OFS, r);
        repeat (40) @(posedge sys_clk_i);
        rdc("next tick", `WCTRL_OFS, {25'h0, r[6:0] - 7'h1});
        chk_rst(1'b0);
        $display("test period done");
    endtask

    task automatic t_warn();
        int n;
        n = 0;
        do_reset(1'b0);
        wr(`WCFG_OFS, 32'h27f);
        wr(`WCTRL_OFS, 32'hc2);
        wr(`WCTRL_OFS, 32'h42);
        rdc("enable kept", `WCTRL_OFS, 32'hc2);
        while (early_warn_irq_o !== 1'b1 && n < 12600) begin
            @(posedge sys_clk_i);
            n++;
        end
        chk("warn irq", 32'h1, {31'h0, early_warn_irq_o});
        chk_rst(1'b0);
        rdc("warn flag", `WSTS_OFS, 32'h1);
        wr(`WSTS_OFS, 32'h0);
        repeat (2) @(posedge sys_clk_i);
        chk("irq cleared", 32'h0, {31'h0, early_warn_irq_o});
        n = 0;
        while (sys_rst_req_o !== 1'b1 && n < 4200) begin
            @(posedge sys_clk_i);
            n++;
        end
        chk_rst(1'b1);
        do_reset(1'b0);
        wr(`WCFG_OFS, 32'h50);
        wr(`WCTRL_OFS, 32'hff);
        chk_rst(1'b0);
        wr(`WCTRL_OFS, 32'h7f);
        repeat (2) @(posedge sys_clk_i);
        chk_rst(1'b1);
        $display("test window done");
    endtask

    task automatic summarize();
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial begin
        do_reset(1'b0);
        t_map();
        t_protect();
        t_indep();
        t_period(2'h0);
        t_period(2'h1);
        t_warn();
        summarize();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        error_cnt++;
        $display("unexpected run length: expected end, seen hang");
        summarize();
    end
endmodule
`default_nettype wire
